// >>> design/cifd_cfg.svh
// register map, field positions and timing counts of the interrupt flag dispatcher
//
// Behaviour
// - an accepted enabled request sends execution to its source's vector address
// - a running service is preempted only by a strictly higher priority request
// - return-from-interrupt ends the service and resumes the interrupted program
// - a source event sets its cpu pending flag and its module flag
// - pending flags set regardless of the enable bits
// - enabled flag is acknowledged next instruction cycle by a forced long call
// - request waits while equal or higher service runs, taken when highest
// - least latency is seven cycles: one to detect, six for the call
// - radio, converter, usart0 rx, usart1 rx cpu flags auto-clear on vectoring
// - after a module flag clear, remaining enabled module flags reassert cpu flag
// - first flag register: usart1 rx bit7, converter bit5, usart0 bit3, radio bit1
// - bits 2 and 0 of first flag register reset to one
// - aes has two flags in second register; either written one raises request
// - global enable bit 7 of enable register blocks all acknowledgement when zero
`ifndef CIFD_CFG_SVH
`define CIFD_CFG_SVH
`define CIFD_A_FLAGS1   8'h88
`define CIFD_A_FLAGS2   8'h98
`define CIFD_A_ENABLE   8'hA8
`define CIFD_A_PRIO     8'hB0
`define CIFD_A_STATUS   8'hC0
`define CIFD_A_MASK     8'hC1
`define CIFD_FLAGS1_RST 8'h05
`define CIFD_B_RES0     0
`define CIFD_B_RADIO    1
`define CIFD_B_RES2     2
`define CIFD_B_USART0   3
`define CIFD_B_CONV     5
`define CIFD_B_USART1   7
`define CIFD_B_AES_LO   0
`define CIFD_B_AES_HI   1
`define CIFD_B_GLOBAL   7
`define CIFD_SRC_AES    4
`define CIFD_N_AUTOCLR  4
`define CIFD_DETECT_CYC 1
`define CIFD_CALL_CYC   6
`define CIFD_VEC_BASE   16'h0003
`define CIFD_VEC_STEP   16'h0008
`define CIFD_EV_TAKEN   0
`define CIFD_EV_RETURN  1
`endif

// >>> design/cifd_flag_cell.sv
// one pending flag bit: hardware set, hardware clear, software write
`timescale 1ns/1ps
module cifd_flag_cell #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic hw_set,
    input  wire logic hw_clr,
    input  wire logic sw_wr,
    input  wire logic sw_val,
    output logic      q
);
    logic flag_ff;
    logic nxt_flag;

    // set first so an event in a write cycle survives
    assign nxt_flag = hw_set ? 1'b1 : (hw_clr ? 1'b0 : (sw_wr ? sw_val : flag_ff));
    assign q = flag_ff;

    // flag storage
    always_ff @(posedge clk) begin
        if (reset) begin
            flag_ff <= RESET_VAL;
        end else begin
            flag_ff <= nxt_flag;
        end
    end
endmodule

// >>> design/cifd_picker.sv
// chooses the request to take from pending flags, enables and nesting state
`timescale 1ns/1ps
module cifd_picker (
    input  wire logic [4:0]        pend,
    input  wire logic [4:0]        en,
    input  wire logic              global_en,
    input  wire logic [4:0]        prio,
    input  wire logic              svc_hi,
    input  wire logic              svc_lo,
    output logic                   win_valid,
    output cifd_pkg::cifd_src_t    win_idx,
    output logic                   win_lvl
);
    logic [4:0] elig;
    logic [4:0] cand;
    logic       use_hi;

    assign elig   = pend & en & {5{global_en}};
    assign use_hi = |(elig & prio);
    // only a strictly higher level than the one in service may win
    assign cand   = use_hi ? (svc_hi ? 5'h00 : (elig & prio))
                           : ((svc_hi | svc_lo) ? 5'h00 : elig);
    assign win_lvl   = use_hi;
    assign win_valid = |cand;

    // lowest index wins within a level
    always_comb begin
        win_idx = 3'h0;
        for (int i = 4; i >= 0; i--) begin
            if (cand[i]) begin
                win_idx = 3'(i);
            end
        end
    end
endmodule

// >>> design/cifd_pkg.sv
// types shared by the interrupt flag dispatcher
package cifd_pkg;
    typedef enum logic [1:0] {CIFD_IDLE, CIFD_DETECT, CIFD_CALL} cifd_state_t;
    typedef logic [2:0] cifd_src_t;
endpackage

// >>> design/cifd_top.sv
// cpu interrupt flag registers, request arbitration and forced long call sequencer
`timescale 1ns/1ps
`include "cifd_cfg.svh"
module cifd_top (
    input  wire logic        CLK,
    input  wire logic        RESET,
    input  wire logic [7:0]  ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic [7:0]       RDATA,
    input  wire logic [4:0]  SRC_EVENT,
    input  wire logic [4:0]  MOD_CLR,
    input  wire logic [4:0]  MOD_ACTIVE,
    input  wire logic        INSTR_DONE,
    input  wire logic        RETURN_DONE,
    output logic             CALL_ACTIVE,
    output logic [15:0]      CALL_VECTOR,
    output logic             VECTOR_TAKEN,
    output logic [1:0]       IN_SERVICE,
    output logic             IRQ
);
    localparam int SRC_POS [4] = '{`CIFD_B_RADIO, `CIFD_B_CONV, `CIFD_B_USART0, `CIFD_B_USART1};

    cifd_pkg::cifd_state_t state_ff;
    cifd_pkg::cifd_state_t nxt_state;
    cifd_pkg::cifd_src_t   idx_ff;
    cifd_pkg::cifd_src_t   win_idx;
    logic        lvl_ff;
    logic        win_lvl;
    logic        win_valid;
    logic [2:0]  cnt_ff;
    logic        svc_hi_ff;
    logic        svc_lo_ff;
    logic [7:0]  ien_ff;
    logic [4:0]  prio_ff;
    logic [1:0]  stat_ff;
    logic [1:0]  mask_ff;
    logic [7:0]  rdata_ff;
    logic        call_ff;
    logic [15:0] vec_ff;
    logic        taken_ff;
    logic        irq_ff;
    logic [3:0]  src_q;
    logic        res0_q;
    logic        res2_q;
    logic        aes_hi_q;
    logic        aes_lo_q;
    logic [4:0]  reassert;
    logic [4:0]  pend;
    logic [7:0]  flags1;
    logic [7:0]  flags2;
    logic [7:0]  rd_mux;
    logic        wr_f1;
    logic        wr_f2;
    logic        take;
    logic        vec_clr;
    logic        call_last;
    logic [1:0]  ev;
    logic        rd_stat;

    ////////////////////////////////////////////////////////////////////////
    // register decode
    assign wr_f1   = WR && (ADDR == `CIFD_A_FLAGS1);
    assign wr_f2   = WR && (ADDR == `CIFD_A_FLAGS2);
    assign rd_stat = RD && (ADDR == `CIFD_A_STATUS);

    // a module flag clear with others still live raises the cpu flag again
    assign reassert = MOD_CLR & MOD_ACTIVE;

    // vectoring clears the chosen flag, unless it is aes, when entering the call
    assign vec_clr = (state_ff == cifd_pkg::CIFD_DETECT);

    ////////////////////////////////////////////////////////////////////////
    // first flag register: four auto-cleared source flags
    for (genvar i = 0; i < `CIFD_N_AUTOCLR; i++) begin : g_src
        cifd_flag_cell #(.RESET_VAL(1'b0)) u_cell (
            .clk    (CLK),
            .reset  (RESET),
            .hw_set (SRC_EVENT[i] | reassert[i]),
            .hw_clr (vec_clr && (idx_ff == 3'(i))),
            .sw_wr  (wr_f1),
            .sw_val (WDATA[SRC_POS[i]]),
            .q      (src_q[i])
        );
    end

    // reserved bits reset to one, software writable
    cifd_flag_cell #(.RESET_VAL(1'b1)) u_res0 (
        .clk    (CLK),
        .reset  (RESET),
        .hw_set (1'b0),
        .hw_clr (1'b0),
        .sw_wr  (wr_f1),
        .sw_val (WDATA[`CIFD_B_RES0]),
        .q      (res0_q)
    );

    cifd_flag_cell #(.RESET_VAL(1'b1)) u_res2 (
        .clk    (CLK),
        .reset  (RESET),
        .hw_set (1'b0),
        .hw_clr (1'b0),
        .sw_wr  (wr_f1),
        .sw_val (WDATA[`CIFD_B_RES2]),
        .q      (res2_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // second flag register: the paired aes flags, both set by the coprocessor
    cifd_flag_cell #(.RESET_VAL(1'b0)) u_aes_hi (
        .clk    (CLK),
        .reset  (RESET),
        .hw_set (SRC_EVENT[`CIFD_SRC_AES] | reassert[`CIFD_SRC_AES]),
        .hw_clr (1'b0),
        .sw_wr  (wr_f2),
        .sw_val (WDATA[`CIFD_B_AES_HI]),
        .q      (aes_hi_q)
    );

    cifd_flag_cell #(.RESET_VAL(1'b0)) u_aes_lo (
        .clk    (CLK),
        .reset  (RESET),
        .hw_set (SRC_EVENT[`CIFD_SRC_AES] | reassert[`CIFD_SRC_AES]),
        .hw_clr (1'b0),
        .sw_wr  (wr_f2),
        .sw_val (WDATA[`CIFD_B_AES_LO]),
        .q      (aes_lo_q)
    );

    // register images and pending vector, unused bits read zero
    assign flags1 = {src_q[3], 1'b0, src_q[1], 1'b0, src_q[2], res2_q, src_q[0], res0_q};
    assign flags2 = {6'h00, aes_hi_q, aes_lo_q};
    assign pend   = {aes_hi_q | aes_lo_q, src_q};

    ////////////////////////////////////////////////////////////////////////
    // arbitration
    cifd_picker u_pick (
        .pend      (pend),
        .en        (ien_ff[4:0]),
        .global_en (ien_ff[`CIFD_B_GLOBAL]),
        .prio      (prio_ff),
        .svc_hi    (svc_hi_ff),
        .svc_lo    (svc_lo_ff),
        .win_valid (win_valid),
        .win_idx   (win_idx),
        .win_lvl   (win_lvl)
    );

    // acknowledged at the next instruction boundary
    assign take      = (state_ff == cifd_pkg::CIFD_IDLE) && INSTR_DONE && win_valid;
    assign call_last = (state_ff == cifd_pkg::CIFD_CALL) && (cnt_ff == 3'(`CIFD_CALL_CYC - 1));

    // sequencer next state
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            cifd_pkg::CIFD_IDLE: begin
                if (take) begin
                    nxt_state = cifd_pkg::CIFD_DETECT;
                end
            end
            cifd_pkg::CIFD_DETECT: begin
                nxt_state = cifd_pkg::CIFD_CALL;
            end
            cifd_pkg::CIFD_CALL: begin
                if (call_last) begin
                    nxt_state = cifd_pkg::CIFD_IDLE;
                end
            end
        endcase
    end

    // state, chosen source and call cycle counter
    always_ff @(posedge CLK) begin
        if (RESET) begin
            state_ff <= cifd_pkg::CIFD_IDLE;
            idx_ff   <= 3'h0;
            lvl_ff   <= 1'b0;
            cnt_ff   <= 3'h0;
        end else begin
            state_ff <= nxt_state;
            if (take) begin
                idx_ff <= win_idx;
                lvl_ff <= win_lvl;
            end
            cnt_ff <= (state_ff == cifd_pkg::CIFD_CALL) ? cnt_ff + 3'h1 : 3'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // nesting levels: set on vectoring, highest one popped on return
    always_ff @(posedge CLK) begin
        if (RESET) begin
            svc_hi_ff <= 1'b0;
            svc_lo_ff <= 1'b0;
        end else if (vec_clr) begin
            svc_hi_ff <= svc_hi_ff | lvl_ff;
            svc_lo_ff <= svc_lo_ff | !lvl_ff;
        end else if (RETURN_DONE) begin
            svc_hi_ff <= 1'b0;
            svc_lo_ff <= svc_hi_ff & svc_lo_ff;
        end
    end

    // forced long call outputs
    always_ff @(posedge CLK) begin
        if (RESET) begin
            call_ff  <= 1'b0;
            vec_ff   <= `CIFD_VEC_BASE;
            taken_ff <= 1'b0;
        end else begin
            call_ff  <= vec_clr | (call_ff & !call_last);
            if (vec_clr) begin
                vec_ff <= `CIFD_VEC_BASE + `CIFD_VEC_STEP * {13'h0000, idx_ff};
            end
            taken_ff <= call_last;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // enable, priority and mask registers
    always_ff @(posedge CLK) begin
        if (RESET) begin
            ien_ff  <= 8'h00;
            prio_ff <= 5'h00;
            mask_ff <= 2'h0;
        end else if (WR) begin
            if (ADDR == `CIFD_A_ENABLE) ien_ff  <= {WDATA[`CIFD_B_GLOBAL], 2'h0, WDATA[4:0]};
            if (ADDR == `CIFD_A_PRIO)   prio_ff <= WDATA[4:0];
            if (ADDR == `CIFD_A_MASK)   mask_ff <= WDATA[1:0];
        end
    end

    // sticky events: a new event beats the read clear
    assign ev = {RETURN_DONE, call_last};
    always_ff @(posedge CLK) begin
        if (RESET) begin
            stat_ff <= 2'h0;
            irq_ff  <= 1'b0;
        end else begin
            stat_ff <= ev | (rd_stat ? 2'h0 : stat_ff);
            irq_ff  <= |((ev | (rd_stat ? 2'h0 : stat_ff)) & mask_ff);
        end
    end

    // read data mux, one cycle after the strobe
    assign rd_mux = (ADDR == `CIFD_A_FLAGS1) ? flags1 :
                    (ADDR == `CIFD_A_FLAGS2) ? flags2 :
                    (ADDR == `CIFD_A_ENABLE) ? ien_ff :
                    (ADDR == `CIFD_A_PRIO)   ? {3'h0, prio_ff} :
                    (ADDR == `CIFD_A_STATUS) ? {6'h00, stat_ff} :
                    (ADDR == `CIFD_A_MASK)   ? {6'h00, mask_ff} : 8'h00;
    always_ff @(posedge CLK) begin
        if (RESET) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= RD ? rd_mux : 8'h00;
        end
    end

    assign RDATA        = rdata_ff;
    assign CALL_ACTIVE  = call_ff;
    assign CALL_VECTOR  = vec_ff;
    assign VECTOR_TAKEN = taken_ff;
    assign IN_SERVICE   = {svc_hi_ff, svc_lo_ff};
    assign IRQ          = irq_ff;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    set_wins_a: assert property (SRC_EVENT[0] |=> src_q[0])
        else $error("radio event lost");
    aes_pair_a: assert property (SRC_EVENT[`CIFD_SRC_AES] |=> aes_hi_q && aes_lo_q)
        else $error("aes flags not both set");
    reassert_a: assert property (MOD_CLR[2] && MOD_ACTIVE[2] |=> src_q[2])
        else $error("usart0 flag not reasserted");
    call_len_a: assert property (state_ff == cifd_pkg::CIFD_DETECT |=> CALL_ACTIVE [*6] ##1 !CALL_ACTIVE)
        else $error("long call not six cycles");
    take_next_a: assert property (take |=> ##1 CALL_ACTIVE)
        else $error("acknowledge late");
    global_off_a: assert property (!ien_ff[`CIFD_B_GLOBAL] && state_ff == cifd_pkg::CIFD_IDLE
        |=> state_ff == cifd_pkg::CIFD_IDLE)
        else $error("taken while globally disabled");
    nest_hold_a: assert property (svc_hi_ff && state_ff == cifd_pkg::CIFD_IDLE && !RETURN_DONE
        |=> state_ff == cifd_pkg::CIFD_IDLE)
        else $error("preempted top level service");
    auto_clr_a: assert property (vec_clr && idx_ff == 3'h0 && !SRC_EVENT[0] && !reassert[0]
        |=> !src_q[0])
        else $error("radio flag not auto cleared");
    vec_addr_a: assert property (VECTOR_TAKEN |-> CALL_VECTOR == `CIFD_VEC_BASE + `CIFD_VEC_STEP * idx_ff)
        else $error("wrong vector");
    return_pop_a: assert property (RETURN_DONE && !vec_clr |=> !svc_hi_ff)
        else $error("return did not pop");
    res_bits_a: assert property ($fell(RESET) |-> flags1[2] && flags1[0])
        else $error("reserved bits not one");
    no_set_en_a: assert property (SRC_EVENT[1] && ien_ff[1] == 1'b0 |=> src_q[1])
        else $error("flag needs enable");
endmodule

// >>> test/cifd_core_model.sv
// cpu core stand-in: instruction boundaries and return-from-interrupt
`timescale 1ns/1ps
module cifd_core_model (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic slow,
    input  wire logic return_req,
    output logic      instr_done,
    output logic      return_done
);
    logic [1:0] phase_ff;

    // slow mode spaces boundaries three cycles apart, like long instructions
    always_ff @(posedge clk) begin
        if (reset) begin
            phase_ff    <= 2'h0;
            instr_done  <= 1'b0;
            return_done <= 1'b0;
        end else begin
            phase_ff    <= (phase_ff == 2'h2) ? 2'h0 : phase_ff + 2'h1;
            instr_done  <= !slow || (phase_ff == 2'h2);
            return_done <= return_req;
        end
    end
endmodule

// >>> test/tb_cpu_interrupt_flag_dispatch.sv
// self-checking bench for the interrupt flag dispatcher
`timescale 1ns/1ps
`include "cifd_cfg.svh"
module tb_cpu_interrupt_flag_dispatch;
    logic        clk, reset, wr, rd, slow, return_req, instr_done, return_done;
    logic [7:0]  addr, wdata, rdata;
    logic [4:0]  src_event, mod_clr, mod_active;
    logic        call_active, vector_taken, irq;
    logic [15:0] call_vector;
    logic [1:0]  in_service;
    int          err_total, comparisons, cycles;

    cifd_top dut (.CLK(clk), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .SRC_EVENT(src_event), .MOD_CLR(mod_clr), .MOD_ACTIVE(mod_active), .INSTR_DONE(instr_done),
        .RETURN_DONE(return_done), .CALL_ACTIVE(call_active), .CALL_VECTOR(call_vector),
        .VECTOR_TAKEN(vector_taken), .IN_SERVICE(in_service), .IRQ(irq));
    cifd_core_model core (.clk(clk), .reset(reset), .slow(slow), .return_req(return_req),
        .instr_done(instr_done), .return_done(return_done));

    // 25 MHz clock and hang guard
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // register bus: one-cycle strobes, read data in the following cycle
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk({8'h00, rdata}, {8'h00, exp});
    endtask

    // peripheral side: event pulses and module flag clears
    task automatic fire(input logic [4:0] ev);
        @(posedge clk);
        src_event <= ev;
        @(posedge clk);
        src_event <= 5'h00;
    endtask

    task automatic mod_clear(input logic [4:0] c, input logic [4:0] act);
        @(posedge clk);
        mod_clr    <= c;
        mod_active <= act;
        @(posedge clk);
        mod_clr    <= 5'h00;
        mod_active <= 5'h00;
    endtask

    task automatic quiet(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
            chk({15'h0000, call_active}, 16'h0000);
        end
    endtask

    task automatic ret();
        @(posedge clk);
        return_req <= 1'b1;
        @(posedge clk);
        return_req <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    // waits for one forced call; lat of zero skips the latency figure
    task automatic expect_call(input logic [15:0] vec, input int lat);
        int n;
        int hi;
        n = 1;
        hi = 0;
        while (vector_taken !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
            if (call_active === 1'b1) begin
                hi++;
                if (hi == 1) chk(call_vector, vec);
            end
        end
        chk({15'h0000, vector_taken}, 16'h0001);
        chk(16'(hi), 16'h0006);
        if (lat != 0) chk(16'(n), 16'(lat));
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        reset = 1'b1;
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        slow = 1'b0;
        return_req = 1'b0;
        src_event = 5'h00;
        mod_clr = 5'h00;
        mod_active = 5'h00;
        err_total = 0;
        comparisons = 0;
        cycles = 0;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        #1;
        chk(call_vector, `CIFD_VEC_BASE);
        chk({14'h0000, in_service}, 16'h0000);
        rd_chk(`CIFD_A_FLAGS1, 8'h05);
        rd_chk(`CIFD_A_FLAGS2, 8'h00);
        rd_chk(`CIFD_A_ENABLE, 8'h00);
        rd_chk(`CIFD_A_PRIO, 8'h00);
        rd_chk(`CIFD_A_MASK, 8'h00);
        wr_reg(8'h55, 8'hFF);
        rd_chk(8'h55, 8'h00);
        // flags set with the global enable off, nothing acknowledged
        wr_reg(`CIFD_A_ENABLE, 8'h1D);
        fire(5'h1F);
        quiet(12);
        rd_chk(`CIFD_A_FLAGS1, 8'hAF);
        rd_chk(`CIFD_A_FLAGS2, 8'h03);
        wr_reg(`CIFD_A_FLAGS1, 8'h05);
        wr_reg(`CIFD_A_FLAGS2, 8'h00);
        mod_clear(5'h0F, 5'h00);
        rd_chk(`CIFD_A_FLAGS1, 8'h05);
        // hardware set against a clearing write in the same cycle
        @(posedge clk);
        addr      <= `CIFD_A_FLAGS1;
        wdata     <= 8'h05;
        wr        <= 1'b1;
        src_event <= 5'h01;
        @(posedge clk);
        wr        <= 1'b0;
        src_event <= 5'h00;
        rd_chk(`CIFD_A_FLAGS1, 8'h07);
        wr_reg(`CIFD_A_FLAGS1, 8'h05);
        // module clear re-raises only where flags remain active
        mod_clear(5'h06, 5'h04);
        rd_chk(`CIFD_A_FLAGS1, 8'h0D);
        wr_reg(`CIFD_A_FLAGS1, 8'h05);
        // each auto-cleared source: vector, latency, status and interrupt
        wr_reg(`CIFD_A_MASK, 8'h01);
        for (int i = 0; i < 4; i++) begin
            wr_reg(`CIFD_A_ENABLE, 8'h80 | (8'h01 << i));
            fire(5'h01 << i);
            expect_call(`CIFD_VEC_BASE + `CIFD_VEC_STEP * 16'(i), 9);
            @(posedge clk);
            #1;
            chk({15'h0000, irq}, 16'h0001);
            chk({14'h0000, in_service}, 16'h0001);
            mod_clear(5'h01 << i, 5'h00);
            rd_chk(`CIFD_A_FLAGS1, 8'h05);
            ret();
            chk({14'h0000, in_service}, 16'h0000);
            rd_chk(`CIFD_A_STATUS, 8'h03);
            chk({15'h0000, irq}, 16'h0000);
        end
        // software-raised aes request stays pending at equal level
        wr_reg(`CIFD_A_ENABLE, 8'h90);
        wr_reg(`CIFD_A_FLAGS2, 8'h02);
        expect_call(16'h0023, 9);
        quiet(12);
        rd_chk(`CIFD_A_FLAGS2, 8'h02);
        wr_reg(`CIFD_A_FLAGS2, 8'h00);
        ret();
        rd_chk(`CIFD_A_STATUS, 8'h03);
        // the low aes flag alone raises the request as well
        wr_reg(`CIFD_A_FLAGS2, 8'h01);
        expect_call(16'h0023, 9);
        wr_reg(`CIFD_A_FLAGS2, 8'h00);
        ret();
        // nesting: high level preempts, equal level waits until return
        wr_reg(`CIFD_A_PRIO, 8'h02);
        wr_reg(`CIFD_A_ENABLE, 8'h83);
        fire(5'h01);
        expect_call(16'h0003, 9);
        fire(5'h03);
        expect_call(16'h000B, 9);
        chk({14'h0000, in_service}, 16'h0003);
        ret();
        chk({14'h0000, in_service}, 16'h0001);
        quiet(12);
        ret();
        expect_call(16'h0003, 0);
        ret();
        chk({14'h0000, in_service}, 16'h0000);
        // slow core stretches the response
        wr_reg(`CIFD_A_PRIO, 8'h00);
        @(posedge clk);
        slow <= 1'b1;
        fire(5'h01);
        expect_call(16'h0003, 0);
        // return-seen status bit alone drives the interrupt through its mask bit
        rd_chk(`CIFD_A_STATUS, 8'h03);
        wr_reg(`CIFD_A_MASK, 8'h02);
        @(posedge clk);
        #1;
        chk({15'h0000, irq}, 16'h0000);
        ret();
        chk({15'h0000, irq}, 16'h0001);
        complete_run();
    end
endmodule
